// ---- design/umc_baud_gen.sv ----
module umc_baud_gen (
  // clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        reset_i,
  // control
  input  wire logic        enable_i,
  input  wire logic [15:0] divisor_i,
  // ticks
  output logic             tick_o,
  output logic             clk16_o
);
  import umc_pkg::*;

  logic [15:0] cnt_q;
  logic [15:0] cnt_d;
  logic        clk_q;
  logic        clk_d;

  // =========================================================
  // divider
  always_comb begin
    tick_o = enable_i && (cnt_q >= divisor_i);
    cnt_d  = tick_o || !enable_i ? 16'h0000 : cnt_q + 16'h0001;
    // square wave, high for the first half of each tick period
    clk_d  = enable_i && (cnt_d <= (divisor_i >> 1));
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      cnt_q <= 16'h0000;
      clk_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      clk_q <= clk_d;
    end
  end

  assign clk16_o = clk_q;
endmodule : umc_baud_gen

// ---- design/umc_pkg.sv ----
package umc_pkg;
  // =========================================================
  // register map
  localparam int unsigned ADDR_W       = 8;
  localparam int unsigned DATA_W       = 32;
  localparam logic [7:0]  OFS_MODE     = 8'h00;
  localparam logic [7:0]  OFS_BAUD     = 8'h04;
  localparam logic [7:0]  OFS_TXDATA   = 8'h08;
  localparam logic [7:0]  OFS_RXDATA   = 8'h0C;
  localparam logic [7:0]  OFS_STATUS   = 8'h10;
  localparam logic [15:0] MODE_WMASK   = 16'hBBFF;
  localparam logic [15:0] MODE_RESET   = 16'h0000;
  localparam logic [15:0] BAUD_RESET   = 16'h0000;
  // =========================================================
  // field positions and codes
  localparam int unsigned RXD_PERR_BIT = 9;
  localparam int unsigned RXD_FERR_BIT = 10;
  localparam int unsigned RXD_VLD_BIT  = 11;
  localparam int unsigned STA_RXV_BIT  = 0;
  localparam int unsigned STA_PEND_BIT = 1;
  localparam int unsigned STA_BUSY_BIT = 2;
  localparam logic [1:0]  PDS_8N       = 2'h0;
  localparam logic [1:0]  PDS_8E       = 2'h1;
  localparam logic [1:0]  PDS_8O       = 2'h2;
  localparam logic [1:0]  PDS_9N       = 2'h3;
  localparam logic [1:0]  PIN_CTS_RTS  = 2'h2;
  localparam logic [1:0]  PIN_BCLK     = 2'h3;
  // =========================================================
  // timing counts in baud ticks, and data bits per character
  localparam logic [3:0]  OVS_STD_MAX  = 4'hF;
  localparam logic [3:0]  OVS_HS_MAX   = 4'h3;
  localparam logic [3:0]  IR_PULSE     = 4'h3;
  localparam logic [3:0]  IR_HOLD      = 4'hF;
  localparam logic [3:0]  BITS_8       = 4'h8;
  localparam logic [3:0]  BITS_9       = 4'h9;
  // =========================================================
  // types
  typedef struct packed {
    logic       port_enable;
    logic       rsv14;
    logic       stop_in_idle;
    logic       infrared_codec_enable;
    logic       rts_pin_mode_select;
    logic       rsv10;
    logic [1:0] pin_enable_field;
    logic       wake;
    logic       loopback_select;
    logic       auto_baud_enable;
    logic       receive_polarity_invert;
    logic       high_speed_baud_select;
    logic [1:0] parity_data_select;
    logic       stop_bit_select;
  } umc_mode_t;

  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } umc_reg_req_t;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_START = 3'b001,
    ST_DATA  = 3'b010,
    ST_PAR   = 3'b011,
    ST_STOP  = 3'b100
  } umc_state_t;
endpackage : umc_pkg

// ---- design/umc_uart.sv ----
module umc_uart (
  // clock and reset
  input  wire logic                 ref_clk_i,
  input  wire logic                 reset_i,
  // register port
  input  wire umc_pkg::umc_reg_req_t reg_req_i,
  output logic [umc_pkg::DATA_W-1:0] reg_rdata_o,
  // serial pins
  input  wire logic                 receive_pin_i,
  input  wire logic                 clear_to_send_pin_n_i,
  output logic                      transmit_pin_o,
  output logic                      request_to_send_pin_n_o
);
  import umc_pkg::*;

  umc_mode_t   mode_q,  mode_d;
  logic [15:0] baud_q,  baud_d;
  logic [8:0]  txd_q,   txd_d;
  logic        pend_q,  pend_d;
  logic [8:0]  rxd_q,   rxd_d;
  logic        perr_q,  perr_d;
  logic        ferr_q,  ferr_d;
  logic        rxv_q,   rxv_d;
  logic [31:0] rdata_q, rdata_d;
  logic        rx_meta_q, rx_sync_q, cts_meta_q, cts_sync_q;
  umc_state_t  tx_st_q, tx_st_d, rx_st_q, rx_st_d;
  logic [3:0]  tx_cnt_q, tx_cnt_d, tx_bit_q, tx_bit_d;
  logic [3:0]  rx_cnt_q, rx_cnt_d, rx_bit_q, rx_bit_d, hold_q, hold_d;
  logic [8:0]  tx_sh_q, tx_sh_d, rx_sh_q, rx_sh_d;
  logic        tx_par_q, tx_par_d, rx_par_q, rx_par_d;
  logic        txo_q, txo_d, rts_q, rts_d;
  logic        tick, clk16, tx_take, rx_done, tx_end, rx_end, rx_mid, tx_line, rx_line;
  logic        ir_act, par_en, par_odd, tx_go, wr_ok;
  logic [3:0]  ovs_max, nbits;
  logic [8:0]  rx_word;

  // =========================================================
  // mode decode
  assign ovs_max = mode_q.high_speed_baud_select ? OVS_HS_MAX : OVS_STD_MAX;
  assign nbits   = (mode_q.parity_data_select == PDS_9N) ? BITS_9 : BITS_8;
  assign par_en  = (mode_q.parity_data_select == PDS_8E) ||
                   (mode_q.parity_data_select == PDS_8O);
  assign par_odd = (mode_q.parity_data_select == PDS_8O);
  // codec refused in 4x mode: pulse width needs sixteenths of a bit
  assign ir_act  = mode_q.port_enable && mode_q.infrared_codec_enable &&
                   !mode_q.high_speed_baud_select;

  umc_baud_gen u_baud (
    .ref_clk_i (ref_clk_i),
    .reset_i   (reset_i),
    .enable_i  (mode_q.port_enable),
    .divisor_i (baud_q),
    .tick_o    (tick),
    .clk16_o   (clk16)
  );

  // =========================================================
  // pin synchronisers
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      rx_meta_q  <= 1'b1;
      rx_sync_q  <= 1'b1;
      cts_meta_q <= 1'b1;
      cts_sync_q <= 1'b1;
    end else begin
      rx_meta_q  <= receive_pin_i;
      rx_sync_q  <= rx_meta_q;
      cts_meta_q <= clear_to_send_pin_n_i;
      cts_sync_q <= cts_meta_q;
    end
  end

  // =========================================================
  // transmitter
  assign tx_go  = pend_q && (mode_q.pin_enable_field != PIN_CTS_RTS || !cts_sync_q);
  assign tx_end = tick && (tx_cnt_q == ovs_max);

  always_comb begin
    tx_st_d  = tx_st_q;
    tx_cnt_d = tx_cnt_q;
    tx_bit_d = tx_bit_q;
    tx_sh_d  = tx_sh_q;
    tx_par_d = tx_par_q;
    tx_take  = 1'b0;
    if (tick && tx_st_q != ST_IDLE) begin
      tx_cnt_d = tx_end ? 4'h0 : tx_cnt_q + 4'h1;
    end
    case (tx_st_q)
      ST_IDLE: begin
        tx_cnt_d = 4'h0;
        if (tx_go && tick) begin
          tx_take  = 1'b1;
          tx_st_d  = ST_START;
          tx_sh_d  = txd_q;
          tx_bit_d = 4'h0;
          tx_par_d = (^txd_q[7:0]) ^ par_odd;
        end
      end
      ST_START: begin
        if (tx_end) begin
          tx_st_d = ST_DATA;
        end
      end
      ST_DATA: begin
        if (tx_end) begin
          tx_sh_d  = {1'b0, tx_sh_q[8:1]};
          tx_bit_d = tx_bit_q + 4'h1;
          if (tx_bit_q == nbits - 4'h1) begin
            tx_bit_d = 4'h0;
            tx_st_d  = par_en ? ST_PAR : ST_STOP;
          end
        end
      end
      ST_PAR: begin
        if (tx_end) begin
          tx_st_d = ST_STOP;
        end
      end
      ST_STOP: begin
        if (tx_end) begin
          if (mode_q.stop_bit_select && tx_bit_q == 4'h0) begin
            tx_bit_d = 4'h1;
          end else begin
            tx_st_d = ST_IDLE;
          end
        end
      end
      default: tx_st_d = ST_IDLE;
    endcase
    if (!mode_q.port_enable) begin
      tx_st_d  = ST_IDLE;
      tx_take  = 1'b0;
    end
    case (tx_st_q)
      ST_START: tx_line = 1'b0;
      ST_DATA:  tx_line = tx_sh_q[0];
      ST_PAR:   tx_line = tx_par_q;
      default:  tx_line = 1'b1;
    endcase
    // zero bits become a short high pulse in the first sixteenths
    if (ir_act) begin
      txo_d = !tx_line && (tx_cnt_q < IR_PULSE);
    end else begin
      txo_d = tx_line;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      tx_st_q  <= ST_IDLE;
      tx_cnt_q <= 4'h0;
      tx_bit_q <= 4'h0;
      tx_sh_q  <= 9'h000;
      tx_par_q <= 1'b0;
      txo_q    <= 1'b1;
    end else begin
      tx_st_q  <= tx_st_d;
      tx_cnt_q <= tx_cnt_d;
      tx_bit_q <= tx_bit_d;
      tx_sh_q  <= tx_sh_d;
      tx_par_q <= tx_par_d;
      txo_q    <= txo_d;
    end
  end

  // =========================================================
  // receiver
  assign rx_end  = tick && (rx_cnt_q == ovs_max);
  assign rx_mid  = tick && (rx_cnt_q == (ovs_max >> 1));
  // a pulse is stretched over a bit so the mid-bit sample sees it
  assign rx_line = ir_act ? !(rx_sync_q || hold_q != 4'h0) : rx_sync_q;
  assign rx_word = (nbits == BITS_9) ? rx_sh_q : {1'b0, rx_sh_q[8:1]};

  always_comb begin
    rx_st_d  = rx_st_q;
    rx_cnt_d = rx_cnt_q;
    rx_bit_d = rx_bit_q;
    rx_sh_d  = rx_sh_q;
    rx_par_d = rx_par_q;
    rx_done  = 1'b0;
    hold_d   = hold_q;
    if (ir_act && rx_sync_q) begin
      hold_d = IR_HOLD;
    end else if (tick && hold_q != 4'h0) begin
      hold_d = hold_q - 4'h1;
    end
    if (tick && rx_st_q != ST_IDLE) begin
      rx_cnt_d = rx_end ? 4'h0 : rx_cnt_q + 4'h1;
    end
    case (rx_st_q)
      ST_IDLE: begin
        rx_cnt_d = 4'h0;
        if (tick && !rx_line) begin
          rx_st_d = ST_START;
        end
      end
      ST_START: begin
        if (rx_mid && rx_line) begin
          rx_st_d = ST_IDLE;
        end else if (rx_end) begin
          rx_st_d  = ST_DATA;
          rx_bit_d = 4'h0;
        end
      end
      ST_DATA: begin
        if (rx_mid) begin
          rx_sh_d = {rx_line, rx_sh_q[8:1]};
        end
        if (rx_end) begin
          rx_bit_d = rx_bit_q + 4'h1;
          if (rx_bit_q == nbits - 4'h1) begin
            rx_st_d = par_en ? ST_PAR : ST_STOP;
          end
        end
      end
      ST_PAR: begin
        if (rx_mid) begin
          rx_par_d = rx_line;
        end
        if (rx_end) begin
          rx_st_d = ST_STOP;
        end
      end
      ST_STOP: begin
        // finish at mid stop bit so a following start edge is caught
        if (rx_mid) begin
          rx_done = 1'b1;
          rx_st_d = ST_IDLE;
        end
      end
      default: rx_st_d = ST_IDLE;
    endcase
    if (!mode_q.port_enable) begin
      rx_st_d = ST_IDLE;
      rx_done = 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      rx_st_q  <= ST_IDLE;
      rx_cnt_q <= 4'h0;
      rx_bit_q <= 4'h0;
      rx_sh_q  <= 9'h000;
      rx_par_q <= 1'b0;
      hold_q   <= 4'h0;
    end else begin
      rx_st_q  <= rx_st_d;
      rx_cnt_q <= rx_cnt_d;
      rx_bit_q <= rx_bit_d;
      rx_sh_q  <= rx_sh_d;
      rx_par_q <= rx_par_d;
      hold_q   <= hold_d;
    end
  end

  // =========================================================
  // registers and pins
  assign wr_ok = reg_req_i.wr && reg_req_i.addr == OFS_TXDATA && !pend_q;

  always_comb begin
    mode_d  = mode_q;
    baud_d  = baud_q;
    txd_d   = wr_ok ? reg_req_i.wdata[8:0] : txd_q;
    pend_d  = (pend_q && !tx_take) || wr_ok;
    rxd_d   = rxd_q;
    perr_d  = perr_q;
    ferr_d  = ferr_q;
    rdata_d = 32'h0000_0000;
    if (reg_req_i.wr && reg_req_i.addr == OFS_MODE) begin
      mode_d = umc_mode_t'(reg_req_i.wdata[15:0] & MODE_WMASK);
    end else if (reg_req_i.wr && reg_req_i.addr == OFS_BAUD) begin
      baud_d = reg_req_i.wdata[15:0];
    end
    // a frame landing with the read keeps its valid flag
    rxv_d = rx_done || (rxv_q && !(reg_req_i.rd && reg_req_i.addr == OFS_RXDATA));
    if (rx_done) begin
      rxd_d  = rx_word;
      perr_d = par_en && (rx_par_q != ((^rx_word[7:0]) ^ par_odd));
      ferr_d = !rx_line;
    end
    if (reg_req_i.rd) begin
      if (reg_req_i.addr == OFS_MODE) begin
        rdata_d[15:0] = mode_q;
      end else if (reg_req_i.addr == OFS_BAUD) begin
        rdata_d[15:0] = baud_q;
      end else if (reg_req_i.addr == OFS_RXDATA) begin
        rdata_d[8:0]          = rxd_q;
        rdata_d[RXD_PERR_BIT] = perr_q;
        rdata_d[RXD_FERR_BIT] = ferr_q;
        rdata_d[RXD_VLD_BIT]  = rxv_q;
      end else if (reg_req_i.addr == OFS_STATUS) begin
        rdata_d[STA_RXV_BIT]  = rxv_q;
        rdata_d[STA_PEND_BIT] = pend_q;
        rdata_d[STA_BUSY_BIT] = (tx_st_q != ST_IDLE);
      end
    end
    if (mode_q.port_enable && mode_q.pin_enable_field == PIN_BCLK) begin
      rts_d = clk16;
    end else if (mode_q.rts_pin_mode_select) begin
      rts_d = (tx_st_q == ST_IDLE);
    end else begin
      rts_d = rxv_q;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      mode_q  <= umc_mode_t'(MODE_RESET);
      baud_q  <= BAUD_RESET;
      txd_q   <= 9'h000;
      pend_q  <= 1'b0;
      rxd_q   <= 9'h000;
      perr_q  <= 1'b0;
      ferr_q  <= 1'b0;
      rxv_q   <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rts_q   <= 1'b1;
    end else begin
      mode_q  <= mode_d;
      baud_q  <= baud_d;
      txd_q   <= txd_d;
      pend_q  <= pend_d;
      rxd_q   <= rxd_d;
      perr_q  <= perr_d;
      ferr_q  <= ferr_d;
      rxv_q   <= rxv_d;
      rdata_q <= rdata_d;
      rts_q   <= rts_d;
    end
  end

  assign reg_rdata_o             = rdata_q;
  assign transmit_pin_o          = txo_q;
  assign request_to_send_pin_n_o = rts_q;

  // =========================================================
  // checks
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);

  sequence s_tx_mid_bit;
    tick && tx_st_q != ST_IDLE && tx_cnt_q != ovs_max;
  endsequence
  property p_ovs;
    s_tx_mid_bit |=> $stable(tx_st_q) && tx_cnt_q == $past(tx_cnt_q) + 4'h1;
  endproperty
  a_ovs: assert property (p_ovs) else $error("bit ended early");
  property p_nine_bits;
    tx_st_q == ST_DATA && tx_end && tx_bit_q == 4'h8 |-> mode_q.parity_data_select == PDS_9N;
  endproperty
  a_nine_bits: assert property (p_nine_bits) else $error("ninth bit sent");
  property p_par_state;
    tx_st_q == ST_PAR |-> par_en;
  endproperty
  a_par_state: assert property (p_par_state) else $error("parity without mode");
  property p_two_stop;
    tx_st_q == ST_STOP && tx_end && tx_bit_q == 4'h0 && mode_q.stop_bit_select
      |=> tx_st_q == ST_STOP && tx_bit_q == 4'h1;
  endproperty
  a_two_stop: assert property (p_two_stop) else $error("second stop missing");
  property p_bypass;
    !ir_act |=> transmit_pin_o == $past(tx_line);
  endproperty
  a_bypass: assert property (p_bypass) else $error("codec not bypassed");
  // 4x mode must leave the pin on the plain line even with the codec bit set
  property p_hs_no_ir;
    mode_q.port_enable && mode_q.high_speed_baud_select
      |=> transmit_pin_o == $past(tx_line);
  endproperty
  a_hs_no_ir: assert property (p_hs_no_ir) else $error("codec in 4x mode");
  property p_ir_idle;
    ir_act && tx_st_q == ST_IDLE |=> !transmit_pin_o;
  endproperty
  a_ir_idle: assert property (p_ir_idle) else $error("ir idle not low");
  property p_simplex;
    mode_q.rts_pin_mode_select && !(mode_q.port_enable && mode_q.pin_enable_field == PIN_BCLK)
      && tx_st_q != ST_IDLE |=> !request_to_send_pin_n_o;
  endproperty
  a_simplex: assert property (p_simplex) else $error("simplex request low");
  property p_bclk;
    mode_q.port_enable && mode_q.pin_enable_field == PIN_BCLK
      |=> request_to_send_pin_n_o == $past(clk16);
  endproperty
  a_bclk: assert property (p_bclk) else $error("baud clock not on pin");
  property p_perr;
    rx_done && !par_en |=> !perr_q && rxv_q;
  endproperty
  a_perr: assert property (p_perr) else $error("parity error flagged");
endmodule : umc_uart

// ---- tb/uart_mode_config_bench.sv ----
`define UMC_CHK(got, exp) \
  begin \
    checks_done++; \
    if ((got) !== (exp)) begin \
      n_mismatch++; \
      $display("FAIL t=%0t got=%0h exp=%0h", $time, (got), (exp)); \
    end \
  end

module uart_mode_config_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import umc_pkg::*;

  // =========================================
  // signals and instances
  logic              ref_clk_i;
  logic              reset_i;
  logic              rx_line;
  logic              cts_n;
  logic              tx_line;
  logic              rts_n;
  umc_reg_req_t      req;
  logic [DATA_W-1:0] rdata;
  logic [31:0]       lfsr_q;
  logic [31:0]       r;
  int                n_mismatch;
  int                checks_done;
  int                t;

  umc_uart uut (
    .ref_clk_i               (ref_clk_i),
    .reset_i                 (reset_i),
    .reg_req_i               (req),
    .reg_rdata_o             (rdata),
    .receive_pin_i           (rx_line),
    .clear_to_send_pin_n_i   (cts_n),
    .transmit_pin_o          (tx_line),
    .request_to_send_pin_n_o (rts_n)
  );

  umc_remote_dev far_end (
    .ref_clk_i       (ref_clk_i),
    .line_from_dut_i (tx_line),
    .line_to_dut_o   (rx_line)
  );

  initial begin
    ref_clk_i = 1'b0;
    forever #4 ref_clk_i = ~ref_clk_i;
  end

  // =========================================
  // helpers
  function automatic logic [31:0] lfsr_step(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_step

  // start, eight data bits lsb first, ninth or parity bit, stop ones
  function automatic logic [12:0] frame_of(logic [8:0] w, logic [1:0] pds, logic bad);
    logic p;
    p = (^w[7:0]) ^ (pds == PDS_8O) ^ bad;
    if (pds == PDS_9N) p = w[8];
    if (pds == PDS_8N) p = 1'b1;
    return {3'b111, p, w[7:0], 1'b0};
  endfunction : frame_of

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    req.wr    <= 1'b1;
    req.addr  <= a;
    req.wdata <= d;
    @(posedge ref_clk_i);
    req.wr <= 1'b0;
  endtask : reg_wr

  // data is only there in the cycle after the strobe
  task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk_i);
    req.rd   <= 1'b1;
    req.addr <= a;
    @(posedge ref_clk_i);
    req.rd <= 1'b0;
    #1;
    d = rdata;
  endtask : reg_rd

  task automatic count_toggles(input int n, output int tg);
    logic prev;
    prev = rts_n;
    tg = 0;
    repeat (n) begin
      @(posedge ref_clk_i);
      #1;
      if (rts_n !== prev) tg++;
      prev = rts_n;
    end
  endtask : count_toggles

  task automatic print_verdict;
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : print_verdict

  // =========================================
  // one configuration: two back-to-back transmits and one receive
  task automatic run_cfg(input logic [4:0] cfg);
    logic        hs, ir, rtsm, bad, ok;
    logic [1:0]  pds;
    logic [8:0]  w0, w1;
    logic [12:0] g, m;
    logic [31:0] q;
    int          len, pre, gap, stp, n;
    hs = cfg[0];
    stp = cfg[1] ? 2 : 1;
    pds = cfg[3:2];
    ir = cfg[4] & ~cfg[0];
    rtsm = cfg[1] ^ cfg[3];
    len = hs ? 4 : 16;
    pre = (pds == PDS_8N) ? 9 : 10;
    m = (13'h1 << pre) - 13'h1;
    lfsr_q = lfsr_step(lfsr_q);
    w0 = lfsr_q[8:0];
    lfsr_q = lfsr_step(lfsr_q);
    w1 = lfsr_q[8:0];
    bad = lfsr_q[20];
    // port off first so a changed idle level is not taken as a start bit
    reg_wr(OFS_MODE, 32'h0);
    far_end.set_idle(~ir);
    reg_wr(OFS_MODE, {16'h0, 1'b1, 2'b00, cfg[4], rtsm, 3'b000, 4'h0, hs, pds, cfg[1]});
    repeat (2) @(posedge ref_clk_i);
    `UMC_CHK(tx_line, ~ir)
    fork
      begin
        far_end.capture(pre, len, ir, 1'b0, g, gap, ok);
        `UMC_CHK(g & m, frame_of(w0, pds, 1'b0) & m)
        `UMC_CHK(gap >= stp * len && gap <= stp * len + 3, 1'b1)
        `UMC_CHK(ok, 1'b1)
        far_end.capture(pre, len, ir, 1'b1, g, gap, ok);
        `UMC_CHK(g & m, frame_of(w1, pds, 1'b0) & m)
      end
      begin
        reg_wr(OFS_TXDATA, {23'h0, w0});
        n = 0;
        do begin
          reg_rd(OFS_STATUS, q);
          n++;
        end while (q[STA_PEND_BIT] !== 1'b0 && n < 100);
        `UMC_CHK(n < 100, 1'b1)
        reg_wr(OFS_TXDATA, {23'h0, w1});
        if (rtsm) `UMC_CHK(rts_n, 1'b0)
      end
    join
    if (rtsm) `UMC_CHK(rts_n, 1'b1)
    reg_rd(OFS_RXDATA, q);
    far_end.send(frame_of(w1, pds, bad), pre + stp, len, ir);
    repeat (4) @(posedge ref_clk_i);
    #1;
    if (!rtsm) `UMC_CHK(rts_n, 1'b1)
    reg_rd(OFS_RXDATA, q);
    `UMC_CHK(q[11:0], {2'b10, bad & (pds == PDS_8E || pds == PDS_8O),
                       (pds == PDS_9N) ? w1 : {1'b0, w1[7:0]}})
    repeat (2) @(posedge ref_clk_i);
    #1;
    if (!rtsm) `UMC_CHK(rts_n, 1'b0)
  endtask : run_cfg

  // =========================================
  // main sequence and watchdog
  initial begin
    req = '0;
    reset_i = 1'b1;
    cts_n = 1'b0;
    lfsr_q = 32'hBDA2;
    n_mismatch = 0;
    checks_done = 0;
    repeat (16) @(posedge ref_clk_i);
    reset_i <= 1'b0;
    reg_rd(OFS_MODE, r);
    `UMC_CHK(r, 32'h0)
    reg_rd(OFS_BAUD, r);
    `UMC_CHK(r, 32'h0)
    reg_wr(OFS_MODE, 32'h0000FFFF);
    reg_rd(OFS_MODE, r);
    `UMC_CHK(r, {16'h0, MODE_WMASK})
    reg_wr(8'h14, 32'h0000FFFF);
    reg_rd(8'h14, r);
    `UMC_CHK(r, 32'h0)
    reg_wr(OFS_BAUD, 32'h0);
    for (int c = 0; c < 32; c++) begin
      run_cfg(c[4:0]);
    end
    // cts pin pair selected: a high cts holds the pending word back
    @(posedge ref_clk_i);
    cts_n <= 1'b1;
    reg_wr(OFS_MODE, 32'h00008200);
    reg_wr(OFS_TXDATA, 32'h000000A5);
    repeat (40) @(posedge ref_clk_i);
    reg_rd(OFS_STATUS, r);
    `UMC_CHK(r[2:1], 2'b01)
    @(posedge ref_clk_i);
    cts_n <= 1'b0;
    repeat (8) @(posedge ref_clk_i);
    reg_rd(OFS_STATUS, r);
    `UMC_CHK(r[2:1], 2'b10)
    reg_wr(OFS_BAUD, 32'h3);
    reg_wr(OFS_MODE, 32'h00008300);
    count_toggles(64, t);
    // tick every 4 clocks, two edges per tick, give or take the first sample
    `UMC_CHK(t >= 30 && t <= 33, 1'b1)
    reg_wr(OFS_MODE, 32'h00000300);
    repeat (4) @(posedge ref_clk_i);
    count_toggles(64, t);
    `UMC_CHK(t, 0)
    print_verdict;
  end

  initial begin
    repeat (90000) @(posedge ref_clk_i);
    n_mismatch++;
    print_verdict;
  end
endmodule : uart_mode_config_bench

// ---- tb/umc_remote_dev.sv ----
module umc_remote_dev (
  // clock
  input  wire logic ref_clk_i,
  // serial lines
  input  wire logic line_from_dut_i,
  output logic      line_to_dut_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // =========================================
  // transmit side of the remote end
  initial line_to_dut_o = 1'b1;

  // only called between frames, so no half frame is ever seen
  task automatic set_idle(input logic lvl);
    @(posedge ref_clk_i);
    line_to_dut_o <= lvl;
  endtask : set_idle

  // ir sends a zero as a three-clock pulse, idle low
  task automatic send(input logic [12:0] fr, input int nb, input int len, input logic ir);
    for (int k = 0; k < nb; k++) begin
      for (int c = 0; c < len; c++) begin
        @(posedge ref_clk_i);
        line_to_dut_o <= ir ? (~fr[k] && c < 3) : fr[k];
      end
    end
    @(posedge ref_clk_i);
    line_to_dut_o <= ~ir;
  endtask : send

  // =========================================
  // receive side: bits from the start edge, then the stop run
  task automatic capture(input int nb, input int len, input logic ir, input logic synced,
                         output logic [12:0] fr, output int gap, output logic ok);
    int off;
    int n;
    off = ir ? 1 : len / 2;
    fr = '0;
    n = 0;
    if (!synced) begin
      do begin
        @(posedge ref_clk_i);
        n++;
      end while (line_from_dut_i !== ir && n < 4000);
    end
    ok = (n < 4000);
    repeat (off) @(posedge ref_clk_i);
    for (int k = 0; k < nb; k++) begin
      fr[k] = line_from_dut_i ^ ir;
      if (k < nb - 1) repeat (len) @(posedge ref_clk_i);
    end
    repeat (len - off) @(posedge ref_clk_i);
    gap = 0;
    while (line_from_dut_i !== ir && gap < 64) begin
      @(posedge ref_clk_i);
      gap++;
    end
  endtask : capture
endmodule : umc_remote_dev
